// ==== pkg/etp_pkg.sv ====
// Constants shared by the eight tap pixel output block.
package etp_pkg;

  // Stream shape.
  localparam int unsigned ETP_TAPS = 8;
  localparam int unsigned ETP_PIX_W = 8;
  localparam int unsigned ETP_WORD_W = ETP_TAPS * ETP_PIX_W;
  localparam int unsigned ETP_ADDR_W = 10;
  localparam int unsigned ETP_TX_W = 28;

  // Line lengths in pixels, full resolution and binned.
  localparam int unsigned ETP_LEN_8K = 8192;
  localparam int unsigned ETP_LEN_4K = 4096;
  localparam int unsigned ETP_LEN_2K = 2048;
  localparam int unsigned ETP_LEN_8K_BIN = 4096;
  localparam int unsigned ETP_LEN_4K_BIN = 2048;
  localparam int unsigned ETP_LEN_2K_BIN = 1024;

  // Model selection codes.
  localparam logic [1:0] ETP_MODEL_2K = 2'h0;
  localparam logic [1:0] ETP_MODEL_4K = 2'h1;
  localparam logic [1:0] ETP_MODEL_8K = 2'h2;

  // Transmitter input positions of port bits 0 to 7 for the three byte ports.
  localparam int unsigned ETP_MAP_P0 [8] = '{0, 1, 2, 3, 4, 6, 27, 5};
  localparam int unsigned ETP_MAP_P1 [8] = '{7, 8, 9, 12, 13, 14, 10, 11};
  localparam int unsigned ETP_MAP_P2 [8] = '{15, 18, 19, 20, 21, 22, 16, 17};

  // Transmitter input positions of the flags.
  localparam int unsigned ETP_BIT_LVAL = 24;
  localparam int unsigned ETP_BIT_DVAL = 26;

  // Link state machine.
  typedef enum logic [1:0] {ETP_IDLE, ETP_RUN} etp_state_t;

  // Index of the last eight pixel group of a line.
  function automatic logic [ETP_ADDR_W-1:0] etp_last_group(input logic [1:0] model,
                                                           input logic bin);
    int unsigned len;
    len = bin ? ETP_LEN_2K_BIN : ETP_LEN_2K;
    if (model == ETP_MODEL_4K)
    begin
      len = bin ? ETP_LEN_4K_BIN : ETP_LEN_4K;
    end
    else if (model == ETP_MODEL_8K)
    begin
      len = bin ? ETP_LEN_8K_BIN : ETP_LEN_8K;
    end
    return ETP_ADDR_W'(len / ETP_TAPS - 1);
  endfunction

endpackage

// ==== hw/etp_pixel_out.sv ====
`timescale 1ns/1ps
module etp_pixel_out (
  // System clock domain.
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Acquisition side, system domain.
  input wire logic i_line_done,
  input wire logic [1:0] i_model,
  input wire logic i_binning,
  output logic o_line_busy,
  // Pixel clock domain.
  input wire logic i_clk_pix,
  // Line store read port, pixel clock domain.
  output logic o_rd_en,
  output logic [etp_pkg::ETP_ADDR_W-1:0] o_rd_addr,
  input wire logic [etp_pkg::ETP_WORD_W-1:0] i_rd_data,
  // Transmitter inputs, pixel clock domain.
  output logic [etp_pkg::ETP_TX_W-1:0] o_tx_x,
  output logic [etp_pkg::ETP_TX_W-1:0] o_tx_y,
  output logic [etp_pkg::ETP_TX_W-1:0] o_tx_z
);

  typedef struct packed {
    logic ack_m;
    logic ack_s;
    logic ack_l;
    logic req_t;
    logic busy;
  } etp_sys_t;

  typedef struct packed {
    logic rst_m;
    logic rst_s;
    logic req_m;
    logic req_s;
    logic req_l;
    logic [1:0] model_m;
    logic [1:0] model_s;
    logic bin_m;
    logic bin_s;
    etp_pkg::etp_state_t st;
    logic ack_t;
    logic rd_en;
    logic rd_v;
    logic [etp_pkg::ETP_ADDR_W-1:0] addr;
    logic [etp_pkg::ETP_ADDR_W-1:0] last;
    logic [etp_pkg::ETP_TX_W-1:0] tx_x;
    logic [etp_pkg::ETP_TX_W-1:0] tx_y;
    logic [etp_pkg::ETP_TX_W-1:0] tx_z;
  } etp_link_t;

  etp_sys_t s_q;
  etp_sys_t s_d;
  etp_link_t l_q;
  etp_link_t l_d;

  // System side: hands a finished line to the link and tracks it until done.
  always_comb
  begin
    logic ack_edge;
    ack_edge = 1'b0;
    s_d = s_q;
    s_d.ack_m = l_q.ack_t;
    s_d.ack_s = s_q.ack_m;
    s_d.ack_l = s_q.ack_s;
    ack_edge = s_q.ack_s ^ s_q.ack_l;
    if (ack_edge)
    begin
      s_d.busy = 1'b0;
    end
    if (i_line_done && (!s_q.busy || ack_edge))
    begin
      s_d.req_t = ~s_q.req_t;
      s_d.busy = 1'b1;
    end
    if (!i_nrst)
    begin
      s_d.ack_l = 1'b0;
      s_d.req_t = 1'b0;
      s_d.busy = 1'b0;
    end
  end

  // System domain registers.
  always_ff @(posedge i_clk_sys)
  begin
    s_q <= s_d;
  end

  // Link side: reads eight pixel groups and formats the transmitter words.
  always_comb
  begin
    logic [etp_pkg::ETP_PIX_W-1:0] tap [etp_pkg::ETP_TAPS];
    for (int k = 0; k < etp_pkg::ETP_TAPS; k++)
    begin
      tap[k] = '0;
    end
    l_d = l_q;
    l_d.rst_m = i_nrst;
    l_d.rst_s = l_q.rst_m;
    l_d.req_m = s_q.req_t;
    l_d.req_s = l_q.req_m;
    l_d.req_l = l_q.req_s;
    l_d.model_m = i_model;
    l_d.model_s = l_q.model_m;
    l_d.bin_m = i_binning;
    l_d.bin_s = l_q.bin_m;
    // The store answers one cycle after the read, so the valid mark trails the read by one.
    l_d.rd_v = l_q.rd_en;

    // tap k takes pixel 8g+k+1, bits 7 to 0 with MSB on top
    for (int k = 0; k < etp_pkg::ETP_TAPS; k++)
    begin
      tap[k] = i_rd_data[k*etp_pkg::ETP_PIX_W +: etp_pkg::ETP_PIX_W];
    end

    l_d.tx_x = '0;
    l_d.tx_y = '0;
    l_d.tx_z = '0;
    // flags and data of one group launch together
    if (l_q.rd_v)
    begin
      for (int b = 0; b < etp_pkg::ETP_PIX_W; b++)
      begin
        l_d.tx_x[etp_pkg::ETP_MAP_P0[b]] = tap[0][b];
        l_d.tx_x[etp_pkg::ETP_MAP_P1[b]] = tap[1][b];
        l_d.tx_x[etp_pkg::ETP_MAP_P2[b]] = tap[2][b];
        l_d.tx_y[etp_pkg::ETP_MAP_P0[b]] = tap[3][b];
        l_d.tx_y[etp_pkg::ETP_MAP_P1[b]] = tap[4][b];
        l_d.tx_y[etp_pkg::ETP_MAP_P2[b]] = tap[5][b];
        l_d.tx_z[etp_pkg::ETP_MAP_P0[b]] = tap[6][b];
        l_d.tx_z[etp_pkg::ETP_MAP_P1[b]] = tap[7][b];
      end
      l_d.tx_x[etp_pkg::ETP_BIT_LVAL] = 1'b1;
      l_d.tx_x[etp_pkg::ETP_BIT_DVAL] = 1'b1;
      l_d.tx_y[etp_pkg::ETP_BIT_LVAL] = 1'b1;
      l_d.tx_y[etp_pkg::ETP_BIT_DVAL] = 1'b1;
      l_d.tx_z[etp_pkg::ETP_BIT_LVAL] = 1'b1;
      l_d.tx_z[etp_pkg::ETP_BIT_DVAL] = 1'b1;
    end

    unique case (l_q.st)
      etp_pkg::ETP_IDLE:
      begin
        l_d.rd_en = 1'b0;
        // start only on a finished line
        if (l_q.req_s != l_q.req_l)
        begin
          l_d.st = etp_pkg::ETP_RUN;
          l_d.addr = '0;
          l_d.last = etp_pkg::etp_last_group(l_q.model_s, l_q.bin_s);
          l_d.rd_en = 1'b1;
        end
      end
      etp_pkg::ETP_RUN:
      begin
        // one read per cycle, no gaps
        if (l_q.addr == l_q.last)
        begin
          // flags fall after the last group
          l_d.rd_en = 1'b0;
          l_d.st = etp_pkg::ETP_IDLE;
          l_d.ack_t = ~l_q.ack_t;
        end
        else
        begin
          l_d.addr = l_q.addr + 1'b1;
        end
      end
      default:
      begin
        l_d.st = etp_pkg::ETP_IDLE;
        l_d.rd_en = 1'b0;
      end
    endcase

    if (!l_q.rst_s)
    begin
      l_d.req_l = 1'b0;
      l_d.st = etp_pkg::ETP_IDLE;
      l_d.ack_t = 1'b0;
      l_d.rd_en = 1'b0;
      l_d.rd_v = 1'b0;
      l_d.addr = '0;
      l_d.last = '0;
      l_d.tx_x = '0;
      l_d.tx_y = '0;
      l_d.tx_z = '0;
    end
  end

  // pixel clock rising edge launches every link side register
  always_ff @(posedge i_clk_pix)
  begin
    l_q <= l_d;
  end

  // Outputs straight from registers.
  assign o_line_busy = s_q.busy;
  assign o_rd_en = l_q.rd_en;
  assign o_rd_addr = l_q.addr;
  assign o_tx_x = l_q.tx_x;
  assign o_tx_y = l_q.tx_y;
  assign o_tx_z = l_q.tx_z;

endmodule // etp_pixel_out

// ==== verif/etp_pixel_out_chk.sv ====
`timescale 1ns/1ps
// Checks stream framing, read order and the busy handshake.
module etp_pixel_out_chk (
  // Watched ports.
  input wire logic i_clk_sys,
  input wire logic i_clk_pix,
  input wire logic i_nrst,
  input wire logic i_line_done,
  input wire logic [1:0] i_model,
  input wire logic i_binning,
  input wire logic o_line_busy,
  input wire logic o_rd_en,
  input wire logic [9:0] o_rd_addr,
  input wire logic [27:0] o_tx_x,
  input wire logic [27:0] o_tx_y,
  input wire logic [27:0] o_tx_z
);
  logic [10:0] run_q, run_d, n;
  // Groups per line, and the count of consecutive line valid cycles.
  assign n = 11'(i_model == 2'h1 ? 512 : i_model == 2'h2 ? 1024 : 256) >> i_binning;
  assign run_d = o_tx_x[24] ? run_q + 11'h1 : 11'h0;
  // Registers the run length on the link clock.
  always_ff @(posedge i_clk_pix) run_q <= run_d;
  default clocking @(posedge i_clk_pix); endclocking
  default disable iff (!i_nrst);
  // First group is read, then both flags rise two cycles later, after the store answers.
  sequence s_open;
    o_rd_addr == 10'h0 ##2 o_tx_x[26:24] == 3'h5;
  endsequence
  a_line_open: assert property ($rose(o_rd_en) |-> s_open)
    else $error("bad line start");
  a_addr_step: assert property (o_rd_en && $past(o_rd_en) |->
    o_rd_addr == $past(o_rd_addr) + 10'h1) else $error("bad read step");
  a_flag_follow: assert property (o_tx_x[24] == $past(o_rd_en, 2))
    else $error("flags out of step");
  a_flags_pair: assert property (o_tx_x[26:23] inside {4'h0, 4'ha} &&
    o_tx_y[26:23] == o_tx_x[26:23] && o_tx_z[26:23] == o_tx_x[26:23]) else $error("flag mix");
  a_idle_zero: assert property (!o_tx_x[24] |-> (o_tx_x | o_tx_y | o_tx_z) == 28'h0)
    else $error("idle not zero");
  a_z_spare: assert property ((o_tx_z & 28'h2ff8000) == 28'h0)
    else $error("spare bit set");
  a_line_len: assert property ($fell(o_tx_x[24]) |-> run_q == n)
    else $error("bad line length");
  a_busy_set: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_line_done && !o_line_busy |=> o_line_busy) else $error("line not taken");
endmodule // etp_pixel_out_chk

// ==== verif/etp_store.sv ====
`timescale 1ns/1ps
// Line store model: answers a read one link cycle later.
module etp_store (
  // Read port.
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_bias,
  output logic [63:0] o_data
);
  logic [63:0] data_q = 64'h5a5a5a5a5a5a5a5a;
  // Tap k of group g is pixel 8g+k+1 plus a bias; idle reads give inverted junk.
  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < 8; k++)
    begin
      data_q[8*k+:8] <= i_en ? 8'(8 * i_addr + k + 1 + i_bias) : ~data_q[8*k+:8];
    end
  end
  assign o_data = data_q;
endmodule // etp_store

// ==== verif/etp_pixel_out_test.sv ====
`timescale 1ns/1ps
// Drives whole lines through the block and checks the transmitter words.
module etp_pixel_out_test;
  logic i_clk_sys = 1'b0, i_clk_pix = 1'b0, i_nrst = 1'b0, i_line_done = 1'b0;
  logic i_binning = 1'b0, o_line_busy, o_rd_en;
  logic [1:0] i_model = 2'h0;
  logic [7:0] bias = 8'h00;
  logic [9:0] o_rd_addr;
  logic [63:0] i_rd_data;
  logic [27:0] o_tx_x, o_tx_y, o_tx_z;
  int n_mismatch = 0, check_count = 0, grp = 0, lens = 0, nline = 0, cyc = 0;
  // System clock at 100 ns, link clock at 48 ns with an unrelated phase.
  initial forever #50 i_clk_sys = ~i_clk_sys;
  initial
  begin
    #13;
    forever #24 i_clk_pix = ~i_clk_pix;
  end
  etp_pixel_out etp_pixel_out_inst (.i_clk_sys, .i_nrst, .i_line_done, .i_model, .i_binning,
    .o_line_busy, .i_clk_pix, .o_rd_en, .o_rd_addr, .i_rd_data, .o_tx_x, .o_tx_y, .o_tx_z);
  etp_store etp_store_inst (.i_clk(i_clk_pix), .i_en(o_rd_en), .i_addr(o_rd_addr),
    .i_bias(bias), .o_data(i_rd_data));
  task automatic report_and_stop();
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Rebuilds one byte of a port from its transmitter input positions.
  function automatic logic [7:0] tap(input logic [27:0] w, input int p);
    for (int b = 0; b < 8; b++)
    begin
      tap[b] = w[p == 0 ? etp_pkg::ETP_MAP_P0[b] : p == 1 ? etp_pkg::ETP_MAP_P1[b] :
        etp_pkg::ETP_MAP_P2[b]];
    end
  endfunction
  always @(negedge i_clk_pix)
  begin
    if (o_tx_x[24] === 1'b1 && o_tx_x[26] === 1'b1)
    begin
      for (int k = 0; k < 8; k++)
      begin
        chk(16'(tap(k < 3 ? o_tx_x : k < 6 ? o_tx_y : o_tx_z, k % 3)),
          16'(8'(8 * grp + k + 1 + bias)));
      end
      grp++;
    end
    else if (grp != 0)
    begin
      lens = grp;
      grp = 0;
      nline++;
    end
  end
  // Gives one acquisition finished pulse.
  task automatic pulse();
    @(posedge i_clk_sys);
    #1 i_line_done = 1'b1;
    @(posedge i_clk_sys);
    #1 i_line_done = 1'b0;
  endtask
  // Sends a line, with an optional refused request, and checks what arrived.
  task automatic run_line(input logic [1:0] m, input logic b, input int n, input logic dup);
    int lines;
    lines = nline;
    @(posedge i_clk_sys);
    #1 i_model = m;
    i_binning = b;
    bias = bias + 8'h35;
    pulse();
    chk(16'(o_line_busy), 16'h1);
    if (dup)
      pulse();
    for (int w = 0; w < 3000 && o_line_busy !== 1'b0; w++) @(negedge i_clk_sys);
    repeat (2) @(negedge i_clk_sys);
    chk(16'(lens), 16'(n / 8));
    chk(16'(nline - lines), 16'h1);
  endtask
  // Every model code with and without binning.
  task automatic t_lengths();
    int len [8] = '{2048, 1024, 4096, 2048, 8192, 4096, 2048, 1024};
    for (int i = 0; i < 8; i++)
      run_line(2'(i / 2), i[0], len[i], 1'b0);
  endtask
  // A request while busy is ignored, then a second line follows once busy has cleared.
  task automatic t_refuse();
    run_line(2'h0, 1'b1, 1024, 1'b1);
    run_line(2'h1, 1'b1, 2048, 1'b0);
  endtask
  // Watchdog on system cycles.
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // Reset, then the scenarios.
  initial
  begin
    repeat (6) @(posedge i_clk_sys);
    #1 i_nrst = 1'b1;
    repeat (4) @(posedge i_clk_sys);
    t_lengths();
    t_refuse();
    report_and_stop();
  end
endmodule // etp_pixel_out_test
bind etp_pixel_out etp_pixel_out_chk etp_pixel_out_chk_inst (.i_clk_sys, .i_clk_pix, .i_nrst,
  .i_line_done, .i_model, .i_binning, .o_line_busy, .o_rd_en, .o_rd_addr, .o_tx_x, .o_tx_y,
  .o_tx_z);
